//--- hw/period_timer_pkg.sv
// shared constants for the period match timer block
`default_nettype none
package period_timer_pkg;

    // ------------------------------
    // register map (byte addresses)
    // ------------------------------
    localparam int          TIMER_STRIDE            = 16;
    localparam logic [7:0]  COUNT_OFFSET            = 8'h00;
    localparam logic [7:0]  PERIOD_OFFSET           = 8'h04;
    localparam logic [7:0]  CONTROL_OFFSET          = 8'h08;
    localparam logic [7:0]  INT_FLAG_REG_ONE_ADDR   = 8'h30;
    localparam logic [7:0]  INT_ENABLE_REG_ONE_ADDR = 8'h34;

    // ------------------------------
    // timer_control field layout
    // ------------------------------
    localparam int          PRESCALE_LSB            = 0;
    localparam int          PRESCALE_W              = 2;
    localparam int          TIMER_ON_BIT            = 2;
    localparam int          POSTSCALE_LSB           = 3;
    localparam int          POSTSCALE_W             = 4;
    localparam int          CONTROL_W               = 7;

    // ------------------------------
    // reset values
    // ------------------------------
    localparam logic [7:0]  COUNT_RESET             = 8'h00;
    localparam logic [7:0]  PERIOD_RESET            = 8'hff;
    localparam logic [6:0]  CONTROL_RESET           = 7'h00;

    // ------------------------------
    // timing: instruction clock is the system clock divided by four
    // ------------------------------
    localparam logic [1:0]  INSTR_DIV_LAST          = 2'h3;
    localparam int          PRESCALE_CNT_W          = 6;

    // ------------------------------
    // bus answers
    // ------------------------------
    localparam logic [1:0]  RESP_OKAY               = 2'b00;
    localparam logic [1:0]  RESP_DECERR             = 2'b11;

    typedef enum logic {
        rd_idle = 1'b0,
        rd_data = 1'b1
    } read_state_type;

    // terminal count of the prescaler: 1, 4, 16 or 64 ticks per step
    function automatic logic [PRESCALE_CNT_W-1:0] prescale_limit(
        input logic [PRESCALE_W-1:0] sel
    );
        case (sel)
            2'b00:   prescale_limit = 6'h00;
            2'b01:   prescale_limit = 6'h03;
            2'b10:   prescale_limit = 6'h0f;
            default: prescale_limit = 6'h3f;
        endcase
    endfunction

endpackage
`default_nettype wire

//--- hw/prescale_divider.sv
// instruction clock divider and selectable input prescaler
`default_nettype none
module prescale_divider
    import period_timer_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  run,
    input  wire logic                  clear_scalers,
    input  wire logic [PRESCALE_W-1:0] prescale_select,
    output logic                       tick
);

    logic [1:0]                instr_q;
    logic [PRESCALE_CNT_W-1:0] pre_q;
    logic                      instr_tick;
    logic                      pre_last;

    // instruction clock edge once in four system clocks
    assign instr_tick = run && (instr_q == INSTR_DIV_LAST);
    assign pre_last   = (pre_q == prescale_limit(prescale_select));
    assign tick       = instr_tick && pre_last;

    // ------------------------------
    // counters; halted when off or asleep so nothing drifts meanwhile
    // ------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn || clear_scalers) begin
            instr_q <= 2'h0;
            pre_q   <= '0;
        end else if (run) begin
            instr_q <= instr_q + 2'h1;
            if (instr_tick) begin
                pre_q <= pre_last ? '0 : pre_q + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

//--- hw/match_counter.sv
// count, period compare and postscaler of one timer
`default_nettype none
module match_counter
    import period_timer_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   tick,
    input  wire logic                   clear_scalers,
    input  wire logic                   count_we,
    input  wire logic                   period_we,
    input  wire logic [7:0]             wdata,
    input  wire logic [POSTSCALE_W-1:0] postscale_select,
    output logic [7:0]                  timer_count,
    output logic [7:0]                  period_value,
    output logic                        match_pulse,
    output logic                        post_event
);

    logic [7:0]             count_q;
    logic [7:0]             period_q;
    logic [POSTSCALE_W-1:0] post_q;
    logic                   post_hit;

    // compare on each prescaled step; match is the timer output
    assign match_pulse  = tick && (count_q == period_q);
    assign post_hit     = (post_q == postscale_select);
    assign post_event   = match_pulse && post_hit;
    assign timer_count  = count_q;
    assign period_value = period_q;

    // ------------------------------
    // count and period; software write beats a counting step
    // ------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q  <= COUNT_RESET;
            period_q <= PERIOD_RESET;
        end else begin
            if (period_we) begin
                period_q <= wdata;
            end
            if (count_we) begin
                count_q <= wdata;
            end else if (match_pulse) begin
                count_q <= COUNT_RESET;
            end else if (tick) begin
                count_q <= count_q + 8'h01;
            end
        end
    end

    // postscaler counts matches, wraps at the selected ratio
    always_ff @(posedge aclk) begin
        if (!aresetn || clear_scalers) begin
            post_q <= '0;
        end else if (match_pulse) begin
            post_q <= post_hit ? '0 : post_q + 1'b1;
        end
    end

endmodule
`default_nettype wire

//--- hw/period_match_timer.sv
// top: three period match timers behind an axi4-lite register slave
`default_nettype none

// Summary of operation
// - three timers, each with readable and writable 8-bit count and period
// - timers run from the instruction clock, system clock divided by four
// - prescaler divides the instruction clock by 1, 4, 16 or 64
// - each prescaled step compares count with period; equality gives match
// - after a match the count reloads to zero instead of incrementing
// - reset clears the count and sets the period to all ones
// - writing count or control clears prescaler and postscaler
// - every device reset clears prescaler and postscaler
// - writing control leaves the count untouched
// - matches advance a 4-bit postscaler; its terminal count sets the flag
// - interrupt request is flag gated by enable; flag sets regardless
// - postscaler offers sixteen ratios, one to sixteen matches per flag
// - unscaled match pulse is exported for the pwm time base
// - timer output is offered as a serial port shift clock
// - in sleep the timer does not count and keeps its registers
// - prescale field 00, 01, 10, 11 select 1, 4, 16, 64
// - postscale field value n selects one flag per n+1 matches
// - period spans period value plus one prescaled steps
module period_match_timer
    import period_timer_pkg::*;
#(
    parameter int NUM_TIMERS = 3
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  sleep_mode,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic [NUM_TIMERS-1:0]      match_pulse,
    output logic [NUM_TIMERS-1:0]      shift_clock,
    output logic [NUM_TIMERS-1:0]      match_int_request
);

    // ------------------------------
    // elaboration check
    // ------------------------------
    // the flag register at 0x30 sits where a fourth timer block would start
    if (NUM_TIMERS < 1 || NUM_TIMERS > 3) begin : g_bad_count
        $error("NUM_TIMERS must lie between 1 and 3");
    end

    // ------------------------------
    // declarations
    // ------------------------------
    // write side and read side state
    logic                    aw_held_q;
    logic [7:0]              aw_addr_q;
    logic                    w_held_q;
    logic [7:0]              w_data_q;
    logic                    w_lane0_q;
    logic                    bvalid_q;
    logic [1:0]              bresp_q;
    read_state_type          rd_state_q;
    read_state_type          rd_state_d;
    logic [31:0]             rdata_q;
    logic [1:0]              rresp_q;

    // per-timer state
    logic [CONTROL_W-1:0]    ctrl_q [NUM_TIMERS];
    logic [NUM_TIMERS-1:0]   flag_q;
    logic [NUM_TIMERS-1:0]   flag_d;
    logic [NUM_TIMERS-1:0]   enable_q;
    logic [NUM_TIMERS-1:0]   shift_q;
    logic [NUM_TIMERS-1:0]   post_event;
    logic [7:0]              count_rd [NUM_TIMERS];
    logic [7:0]              period_rd [NUM_TIMERS];

    // write strobes and run enables
    logic                    do_write;
    logic                    wr_mapped;
    logic                    flag_wr;
    logic                    enable_wr;
    logic [NUM_TIMERS-1:0]   count_wr;
    logic [NUM_TIMERS-1:0]   period_wr;
    logic [NUM_TIMERS-1:0]   control_wr;
    logic [NUM_TIMERS-1:0]   clear_scalers;
    logic [NUM_TIMERS-1:0]   run;

    // read decode
    logic                    ar_take;
    logic [31:0]             rd_word;
    logic                    rd_mapped;

    // ------------------------------
    // write channel handshakes
    // ------------------------------
    // address and data are taken in either order and held until both
    // are in; nothing new is accepted while the response is pending
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign do_write      = aw_held_q && w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // single-register decode of the held write address
    assign flag_wr   = do_write && w_lane0_q
                       && (aw_addr_q == INT_FLAG_REG_ONE_ADDR);
    assign enable_wr = do_write && w_lane0_q
                       && (aw_addr_q == INT_ENABLE_REG_ONE_ADDR);

    // per-timer decode: upper nibble picks the timer, word picks the reg
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_wr_decode
        localparam logic [7:0] BASE = 8'(i * TIMER_STRIDE);
        assign count_wr[i]   = do_write && w_lane0_q
                               && (aw_addr_q == (BASE | COUNT_OFFSET));
        assign period_wr[i]  = do_write && w_lane0_q
                               && (aw_addr_q == (BASE | PERIOD_OFFSET));
        assign control_wr[i] = do_write && w_lane0_q
                               && (aw_addr_q == (BASE | CONTROL_OFFSET));
    end

    // a write with lane 0 off still gets OKAY when the address is mapped
    assign wr_mapped = (aw_addr_q == INT_FLAG_REG_ONE_ADDR)
                       || (aw_addr_q == INT_ENABLE_REG_ONE_ADDR)
                       || (aw_addr_q[7:4] < 4'(NUM_TIMERS)
                           && aw_addr_q[3:0] <= CONTROL_OFFSET[3:0]
                           && aw_addr_q[1:0] == 2'b00);

    // write address holding register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    // write data holding register; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane0_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q  <= 1'b1;
            w_data_q  <= s_axi_wdata[7:0];
            w_lane0_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------
    // read channel
    // ------------------------------
    // arready only while idle
    assign ar_take       = s_axi_arvalid && (rd_state_q == rd_idle);
    assign s_axi_arready = (rd_state_q == rd_idle);
    assign s_axi_rvalid  = (rd_state_q == rd_data);
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // read mux; reserved and unused bits read as zero
    always_comb begin
        rd_word   = 32'h0000_0000;
        rd_mapped = 1'b0;
        if (s_axi_araddr[7:2] == INT_FLAG_REG_ONE_ADDR[7:2]) begin
            rd_word   = 32'(flag_q);
            rd_mapped = 1'b1;
        end else if (s_axi_araddr[7:2] == INT_ENABLE_REG_ONE_ADDR[7:2]) begin
            rd_word   = 32'(enable_q);
            rd_mapped = 1'b1;
        end else begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (s_axi_araddr[7:4] == 4'(i)) begin
                    if (s_axi_araddr[3:2] == COUNT_OFFSET[3:2]) begin
                        rd_word   = 32'(count_rd[i]);
                        rd_mapped = 1'b1;
                    end else if (s_axi_araddr[3:2] == PERIOD_OFFSET[3:2]) begin
                        rd_word   = 32'(period_rd[i]);
                        rd_mapped = 1'b1;
                    end else if (s_axi_araddr[3:2] == CONTROL_OFFSET[3:2]) begin
                        rd_word   = 32'(ctrl_q[i]);
                        rd_mapped = 1'b1;
                    end
                end
            end
        end
    end

    // read state machine: one read at a time, data held until taken
    always_comb begin
        rd_state_d = rd_state_q;
        case (rd_state_q)
            rd_idle: begin
                if (ar_take) begin
                    rd_state_d = rd_data;
                end
            end
            default: begin
                if (s_axi_rready) begin
                    rd_state_d = rd_idle;
                end
            end
        endcase
    end

    // read state and answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= rd_idle;
            rdata_q    <= 32'h0000_0000;
            rresp_q    <= RESP_OKAY;
        end else begin
            rd_state_q <= rd_state_d;
            if (ar_take) begin
                rdata_q <= rd_word;
                rresp_q <= rd_mapped ? RESP_OKAY : RESP_DECERR;
            end
        end
    end

    // ------------------------------
    // timers
    // ------------------------------
    // one chain per timer
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
        // count or control write restarts the scaler chains
        assign clear_scalers[i] = count_wr[i] || control_wr[i];
        // halted when off or while the processor sleeps
        assign run[i] = ctrl_q[i][TIMER_ON_BIT] && !sleep_mode;

        logic tick;

        // divider and prescaler
        prescale_divider u_prescale (
            .aclk            (aclk),
            .aresetn         (aresetn),
            .run             (run[i]),
            .clear_scalers   (clear_scalers[i]),
            .prescale_select (ctrl_q[i][PRESCALE_LSB +: PRESCALE_W]),
            .tick            (tick)
        );

        // count and postscaler
        match_counter u_match (
            .aclk             (aclk),
            .aresetn          (aresetn),
            .tick             (tick),
            .clear_scalers    (clear_scalers[i]),
            .count_we         (count_wr[i]),
            .period_we        (period_wr[i]),
            .wdata            (w_data_q),
            .postscale_select (ctrl_q[i][POSTSCALE_LSB +: POSTSCALE_W]),
            .timer_count      (count_rd[i]),
            .period_value     (period_rd[i]),
            .match_pulse      (match_pulse[i]),
            .post_event       (post_event[i])
        );

        // control register; count is not touched by this write
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ctrl_q[i] <= CONTROL_RESET;
            end else if (control_wr[i]) begin
                ctrl_q[i] <= w_data_q[CONTROL_W-1:0];
            end
        end
    end

    // ------------------------------
    // shift clock: toggles on each match, giving a clean square wave
    // ------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_q <= '0;
        end else begin
            shift_q <= shift_q ^ match_pulse;
        end
    end

    // registered level, no glitch
    assign shift_clock = shift_q;

    // ------------------------------
    // match flags and enables
    // ------------------------------
    // a zero written clears a flag, a one leaves it; a postscaler event
    // in the same cycle wins so no event is lost
    assign flag_d = flag_wr
                    ? ((flag_q & w_data_q[NUM_TIMERS-1:0]) | post_event)
                    : (flag_q | post_event);

    // flags and enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_q   <= '0;
            enable_q <= '0;
        end else begin
            flag_q <= flag_d;
            if (enable_wr) begin
                enable_q <= w_data_q[NUM_TIMERS-1:0];
            end
        end
    end

    // flag sets regardless; only the request is gated
    assign match_int_request = flag_q & enable_q;

endmodule
`default_nettype wire

//--- bench/period_timer_monitor.sv
// port checker for the period match timer
`default_nettype none
module period_timer_monitor
    import period_timer_pkg::*;
#(
    parameter int NUM_TIMERS = 3
) (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  sleep_mode,
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire logic [31:0]           s_axi_rdata,
    input wire logic [NUM_TIMERS-1:0] match_pulse,
    input wire logic [NUM_TIMERS-1:0] shift_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------
    // handshake steps and timer outputs
    // ------------------------------
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_write_answer: assert property (
        wr_taken |=> ##1 s_axi_bvalid) else $error("write not answered");
    chk_bvalid_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b lost");
    chk_read_answer: assert property (
        rd_taken |=> s_axi_rvalid) else $error("read not answered");
    chk_rdata_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    chk_read_refused: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
    // steps come from the quarter-rate clock, so pulses are at least 4 apart
    chk_pulse_spacing: assert property (
        match_pulse[0] |=> !match_pulse[0] [*3]) else $error("pulse spacing");
    chk_shift_follows: assert property (
        $past(aresetn) |-> shift_clock[0] ==
        ($past(shift_clock[0]) ^ $past(match_pulse[0])))
        else $error("shift clock");
    chk_sleep_frozen: assert property (
        sleep_mode && $past(sleep_mode) |-> match_pulse == '0)
        else $error("pulse in sleep");
endmodule

bind period_match_timer period_timer_monitor
    #(.NUM_TIMERS(NUM_TIMERS)) mon (.aclk, .aresetn, .sleep_mode,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .match_pulse, .shift_clock);
`default_nettype wire

//--- bench/pwm_base_model.sv
// time base consumer: counts match pulses and their spacing
`default_nettype none
module pwm_base_model (
    input  wire logic aclk,
    input  wire logic base_pulse,
    output int        n_pulses,
    output int        gap
);
    timeunit 1ns;
    timeprecision 1ns;
    int since;
    // spacing in aclk cycles is what a pwm period is built on
    initial begin
        n_pulses = 0;
        gap = 0;
        since = 0;
    end
    always @(posedge aclk) begin
        since <= since + 1;
        if (base_pulse === 1'b1) begin
            n_pulses <= n_pulses + 1;
            gap <= since;
            since <= 1;
        end
    end
endmodule
`default_nettype wire

//--- bench/tb_period_match_timer.sv
// self-checking bench for the period match timer
`default_nettype none
module tb_period_match_timer
    import period_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk, aresetn, sleep_mode, awv, wv, bre, arv, rre;
    logic        awr, wrdy, bv, arr, rv;
    logic [1:0]  br, rr, r;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdat, d, a;
    logic [2:0]  mp, sc, irq;
    int          mismatches, n_tests, cyc, s, n_pulses, gap;

    period_match_timer DUT (.aclk(aclk), .aresetn(aresetn),
        .sleep_mode(sleep_mode), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .match_pulse(mp),
        .shift_clock(sc), .match_int_request(irq));
    pwm_base_model far (.aclk(aclk), .base_pulse(mp[0]),
        .n_pulses(n_pulses), .gap(gap));
    // ------------------------------
    // bus helpers
    // ------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t got %h want %h", $time, g, e);
        end
    endtask
    // bready comes late: the slave must hold its answer
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        logic ok_a, ok_w;
        ok_a = 1'b0;
        ok_w = 1'b0;
        awa <= ad; wd <= {24'h0, v}; awv <= 1'b1; wv <= 1'b1;
        while (!(ok_a && ok_w)) begin
            @(posedge aclk);
            if (awv && awr) begin ok_a = 1'b1; awv <= 1'b0; end
            if (wv && wrdy) begin ok_w = 1'b1; wv <= 1'b0; end
        end
        while (bv !== 1'b1) @(posedge aclk);
        bre <= 1'b1;
        @(posedge aclk);
        r = br; bre <= 1'b0;
        chk(32'(r), 32'(RESP_OKAY));
    endtask
    task automatic rd(input logic [7:0] ad);
        ara <= ad; arv <= 1'b1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge aclk); while (rv !== 1'b1);
        rre <= 1'b1;
        @(posedge aclk);
        d = rdat; r = rr; rre <= 1'b0;
    endtask
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic pulses(input int k);
        s = n_pulses;
        while (n_pulses < s + k) @(posedge aclk);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    task automatic t_reset();
        for (logic [7:0] b = 8'h00; b < 8'h30; b += 8'h10) begin
            rd(b + COUNT_OFFSET); chk(d, 32'h0);
            rd(b + PERIOD_OFFSET); chk(d, 32'h0000_00ff);
            rd(b + CONTROL_OFFSET); chk(d, 32'h0);
        end
        rd(8'h3c); chk(32'(r), 32'(RESP_DECERR));
    endtask
    // every prescale code, then a period of three steps
    task automatic t_steps();
        for (int p = 0; p < 4; p++) begin
            wr(PERIOD_OFFSET, 8'h00); wr(COUNT_OFFSET, 8'h00);
            wr(CONTROL_OFFSET, 8'(4 + p)); pulses(2);
            chk(32'(gap), 32'(4 << (2 * p)));
        end
        wr(PERIOD_OFFSET, 8'h02); rd(PERIOD_OFFSET); chk(d, 32'h2);
        wr(CONTROL_OFFSET, 8'h04); pulses(2);
        chk(32'(gap), 32'd12);
    endtask
    // every postscale code, then enable gating and flag clearing
    task automatic t_post();
        wr(INT_ENABLE_REG_ONE_ADDR, 8'h01);
        for (int n = 0; n < 16; n++) begin
            wr(CONTROL_OFFSET, 8'h00); wr(INT_FLAG_REG_ONE_ADDR, 8'h00);
            s = n_pulses; wr(CONTROL_OFFSET, 8'(n * 8 + 4));
            while (irq[0] !== 1'b1) @(posedge aclk);
            chk(32'(n_pulses - s), 32'(n + 1));
        end
        wr(CONTROL_OFFSET, 8'h00); wr(INT_ENABLE_REG_ONE_ADDR, 8'h00);
        chk(32'(irq), 32'h0);
        rd(INT_FLAG_REG_ONE_ADDR); chk(d, 32'h1);
        wr(INT_FLAG_REG_ONE_ADDR, 8'h01); rd(INT_FLAG_REG_ONE_ADDR);
        chk(d, 32'h1);
        wr(INT_FLAG_REG_ONE_ADDR, 8'h00); rd(INT_FLAG_REG_ONE_ADDR);
        chk(d, 32'h0);
    endtask
    // count writes every 10 cycles starve a 16-cycle step of its tick
    task automatic t_clear();
        wr(PERIOD_OFFSET, 8'h00); wr(CONTROL_OFFSET, 8'h05);
        s = n_pulses;
        repeat (6) begin
            wr(COUNT_OFFSET, 8'h00);
            repeat (6) @(posedge aclk);
        end
        chk(32'(n_pulses - s), 32'h0);
        wr(CONTROL_OFFSET, 8'h00); wr(COUNT_OFFSET, 8'h37);
        wr(CONTROL_OFFSET, 8'h01); rd(COUNT_OFFSET); chk(d, 32'h37);
    endtask
    task automatic t_sleep();
        wr(PERIOD_OFFSET, 8'hff); wr(CONTROL_OFFSET, 8'h04);
        sleep_mode <= 1'b1; rd(COUNT_OFFSET); a = d;
        repeat (40) @(posedge aclk);
        rd(COUNT_OFFSET); chk(d, a);
        sleep_mode <= 1'b0;
        repeat (40) @(posedge aclk);
        rd(COUNT_OFFSET); chk(32'(d > a), 32'h1);
    endtask
    // clock, and a cycle ceiling well above the run
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        aclk = 1'b0; aresetn = 1'b0; sleep_mode = 1'b0; awv = 1'b0;
        wv = 1'b0; bre = 1'b0; arv = 1'b0; rre = 1'b0; awa = 8'h0;
        ara = 8'h0; wd = 32'h0; mismatches = 0; n_tests = 0; cyc = 0;
        do_reset(); t_reset(); t_steps(); t_post(); t_clear(); t_sleep();
        do_reset(); t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
